// *** include/lpr_defs.svh ***
// Register offsets, field positions and reset values of the line and polygon rasterizer.
// Assumes a 32-bit classic Wishbone slave with 8-bit byte addresses.
// Overview of operation
// R1 - AA line coverage from width rectangle overlap
// R2 - Width 1.0 supported; width range readable
// R3 - Stippled AA line split into unit pieces
// R4 - Line pieces skip culling and polygon stipple
// R5 - Line state reset values and stipple counter
// R6 - Multisampled lines cover pixels with any sample
// R7 - Sample coverage bit set inside retained piece
// R8 - Line depth per sample by projection
// R9 - Signed area by shoelace, origin sign factor
// R10 - Winding select inverts area sign
// R11 - Positive area front, else back facing
// R12 - Discard faces by cull enable and select
// R13 - Centers inside; shared edges drawn once
// R14 - Perspective-correct attributes at fragment center
// R15 - Depth is plain barycentric weighted sum
// R16 - Linear, flat and perspective attribute modes
// R17 - Larger polygons as triangles, exact at vertices
// R18 - Polygon stipple bit at x,y mod 32
// R19 - Stipple off passes all; AA irrelevant
// R20 - Line stipple bit floor(count/repeat) mod 16
// R21 - Stipple counter clears at primitive restart
// R22 - Removed fragments never output; order kept
`ifndef LPR_DEFS_SVH
`define LPR_DEFS_SVH

`define LPR_A_CTRL   8'h00
`define LPR_A_LINEW  8'h04
`define LPR_A_LSTIP  8'h08
`define LPR_A_AMODE  8'h0C
`define LPR_A_STAT   8'h10
`define LPR_A_WINFO  8'h14

`define LPR_B_LAA    0
`define LPR_B_LSTEN  1
`define LPR_B_MSEN   2
`define LPR_B_ORG    3
`define LPR_B_WIND   4
`define LPR_B_CULL   5
`define LPR_B_DFACE  6
`define LPR_B_PSTEN  8

`define LPR_CTRL_MASK 32'h0000_01FF
`define LPR_R_CTRL    32'h0000_0088
`define LPR_R_LINEW   12'h010
`define LPR_R_PAT     16'hFFFF
`define LPR_R_REP     9'h001
`define LPR_MAX_REP   9'h100
`define LPR_R_ROW     32'hFFFF_FFFF

`define LPR_AM_NOPERSP 2'h1
`define LPR_AM_FLAT    2'h2
`define LPR_CENTER     4'h8

`endif

// *** include/lpr_pkg.sv ***
// Types shared by the line and polygon rasterizer.
// Assumes nothing of its surroundings.
package lpr_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_SETUP,
    S_SCAN
  } lpr_state_type;

endpackage

// *** rtl/lpr_raster.sv ***
// Antialiased and multisampled line and triangle rasterizer with masking.
// Assumes setup logic on the same clock and a Wishbone master for the registers.
`timescale 1ns/1ps
`include "lpr_defs.svh"
module lpr_raster import lpr_pkg::*; #(
  parameter int          NATTR          = 2,
  parameter int          AW             = 16,
  parameter int          SGRID          = 2,
  parameter int          SAMPLE_BUFFERS = 1,
  parameter logic [11:0] AA_WMAX        = 12'h040,
  parameter logic [7:0]  AA_WSTEPS      = 8'h31
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  // Primitive setup
  input  wire logic                            prim_valid_i,
  output logic                                 prim_ready_o,
  input  wire logic                            prim_line_i,
  input  wire logic                            prim_restart_i,
  input  wire logic [1:0]                      prim_provoke_i,
  input  wire logic [2:0][15:0]                v_x_i,
  input  wire logic [2:0][15:0]                v_y_i,
  input  wire logic [2:0][15:0]                v_z_i,
  input  wire logic [2:0][15:0]                v_q_i,
  input  wire logic [2:0][NATTR-1:0][AW-1:0]   v_attr_i,
  input  wire logic [15:0]                     line_ux_i,
  input  wire logic [15:0]                     line_uy_i,
  input  wire logic [15:0]                     line_len_i,
  // Fragments
  output logic                                 frag_valid_o,
  input  wire logic                            frag_ready_i,
  output logic      [10:0]                     frag_x_o,
  output logic      [10:0]                     frag_y_o,
  output logic                                 frag_front_o,
  output logic      [SGRID*SGRID-1:0]          frag_cov_mask_o,
  output logic      [$clog2(SGRID*SGRID+1)-1:0] frag_cov_count_o,
  output logic      [15:0]                     frag_z_o,
  output logic      [SGRID*SGRID-1:0][15:0]    frag_sample_z_o,
  output logic      [NATTR-1:0][AW-1:0]        frag_attr_o
);

  localparam int NS = SGRID * SGRID;
  localparam int CW = $clog2(NS + 1);

  if (!(SGRID == 1 || SGRID == 2 || SGRID == 4) || NATTR < 1 || NATTR > 16 ||
      AW < 1 || AW > 16 || AA_WMAX < `LPR_R_LINEW) begin : g_bad
    $error("lpr_raster: unsupported parameter values");
  end

  function automatic logic [31:0] lpr_bytes(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] lpr_udiv(input logic [63:0] n, input logic [39:0] d);
    logic [40:0] r;
    logic [63:0] q;
    r = '0;
    q = '0;
    if (d == 40'h0) return 32'h0;
    for (int i = 63; i >= 0; i--) begin
      r = {r[39:0], n[i]};
      if (r >= {1'b0, d}) begin
        r = r - {1'b0, d};
        q[i] = 1'b1;
      end
    end
    return (|q[63:32]) ? 32'hFFFF_FFFF : q[31:0];
  endfunction

  function automatic logic signed [35:0] lpr_edge(input logic signed [15:0] ax, ay, bx, by,
                                                  input logic signed [15:0] px, py);
    logic signed [35:0] dx, dy, qx, qy;
    dx = 36'(bx) - 36'(ax);
    dy = 36'(by) - 36'(ay);
    qx = 36'(px) - 36'(ax);
    qy = 36'(py) - 36'(ay);
    return dx * qy - dy * qx;
  endfunction

  function automatic logic [63:0] lpr_wsum(input logic [35:0] e0, e1, e2,
                                           input logic [15:0] v0, v1, v2);
    return 64'(e0) * 64'(v0) + 64'(e1) * 64'(v1) + 64'(e2) * 64'(v2);
  endfunction

  function automatic logic [10:0] lpr_pix(input logic signed [17:0] v);
    if (v < 0) return 11'h0;
    if (v[17:15] != 3'h0) return 11'h7FF;
    return v[14:4];
  endfunction

  // Register file.
  logic [31:0]       ctrl;
  logic [11:0]       line_w;
  logic [15:0]       lpat;
  logic [8:0]        lrep;
  logic [31:0]       amode;
  logic [31:0][31:0] pstip;
  logic [31:0]       rdata;
  logic [31:0]       wv_w;
  logic [31:0]       wv_s;
  logic              wr;
  logic              laa;
  logic              msaa;

  assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign wv_w = lpr_bytes({20'h0, line_w}, wb_dat_i, wb_sel_i);
  assign wv_s = lpr_bytes({7'h0, lrep, lpat}, wb_dat_i, wb_sel_i);
  assign laa  = ctrl[`LPR_B_LAA];
  assign msaa = ctrl[`LPR_B_MSEN] && (SAMPLE_BUFFERS == 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= `LPR_R_CTRL; // R5 R10 R12
      line_w <= `LPR_R_LINEW; // R5
      lpat   <= `LPR_R_PAT; // R5
      lrep   <= `LPR_R_REP; // R5
      amode  <= 32'h0;
      for (int i = 0; i < 32; i++) pstip[i] <= `LPR_R_ROW;
    end else if (wr) begin
      if (wb_adr_i[7]) begin
        pstip[wb_adr_i[6:2]] <= lpr_bytes(pstip[wb_adr_i[6:2]], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `LPR_A_CTRL) begin
        ctrl <= lpr_bytes(ctrl, wb_dat_i, wb_sel_i) & `LPR_CTRL_MASK;
      end else if (wb_adr_i == `LPR_A_LINEW) begin
        // Widths outside the supported range are clamped into it.
        if (wv_w[31:12] != 20'h0 || wv_w[11:0] > AA_WMAX) line_w <= AA_WMAX; // R2
        else if (wv_w[11:0] < `LPR_R_LINEW) line_w <= `LPR_R_LINEW; // R2
        else line_w <= wv_w[11:0];
      end else if (wb_adr_i == `LPR_A_LSTIP) begin
        lpat <= wv_s[15:0];
        if (wv_s[31:16] == 16'h0) lrep <= `LPR_R_REP;
        else if (wv_s[31:16] > 16'(`LPR_MAX_REP)) lrep <= `LPR_MAX_REP;
        else lrep <= wv_s[24:16];
      end else if (wb_adr_i == `LPR_A_AMODE) begin
        amode <= lpr_bytes(amode, wb_dat_i, wb_sel_i) & 32'((64'h1 << (2 * NATTR)) - 64'h1);
      end
    end
  end

  // Primitive capture and scan control.
  lpr_state_type                   state;
  logic                            p_line;
  logic [1:0]                      p_prov;
  logic signed [2:0][15:0]         px;
  logic signed [2:0][15:0]         py;
  logic [2:0][15:0]                pz;
  logic [2:0][15:0]                pq;
  logic [2:0][NATTR-1:0][AW-1:0]   pattr;
  logic signed [15:0]              pux;
  logic signed [15:0]              puy;
  logic [15:0]                     plen;
  logic [23:0]                     stip_base;
  logic [10:0]                     cur_x;
  logic [10:0]                     cur_y;
  logic                            front_r;
  logic                            culled_r;

  assign prim_ready_o = (state == S_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_line <= 1'b0;
      p_prov <= 2'h0;
      px     <= '0;
      py     <= '0;
      pz     <= '0;
      pq     <= '0;
      pattr  <= '0;
      pux    <= '0;
      puy    <= '0;
      plen   <= '0;
    end else if (prim_valid_i && prim_ready_o) begin
      p_line <= prim_line_i;
      p_prov <= (prim_provoke_i == 2'h3) ? 2'h2 : prim_provoke_i;
      px     <= v_x_i;
      py     <= v_y_i;
      pz     <= v_z_i;
      pq     <= v_q_i;
      pattr  <= v_attr_i;
      pux    <= line_ux_i;
      puy    <= line_uy_i;
      plen   <= line_len_i;
    end
  end

  // Facing, orientation and edge tie-break of the captured triangle.
  logic signed [35:0] area2;
  logic               front;
  logic               neg;
  logic               cull_now;
  logic [2:0]         incl;
  logic signed [17:0] lo_x;
  logic signed [17:0] lo_y;
  logic signed [17:0] hi_x;
  logic signed [17:0] hi_y;
  logic [10:0]        hw;

  assign hw = line_w[11:1];

  always_comb begin
    logic signed [35:0] dxe;
    logic signed [35:0] dye;
    logic signed [17:0] m;
    dxe   = 36'sh0;
    dye   = 36'sh0;
    m     = 18'sh0;
    area2 = 36'sh0;
    incl  = 3'h0;
    for (int i = 0; i < 3; i++) begin
      area2 = area2 + 36'(px[i]) * 36'(py[(i+1)%3]) - 36'(px[(i+1)%3]) * 36'(py[i]); // R9
    end
    neg   = area2 < 0;
    // Origin factor and winding select each flip the sign; zero area is back facing.
    front = (area2 != 0) && ((area2 > 0) ^ ~ctrl[`LPR_B_ORG] ^ ctrl[`LPR_B_WIND]); // R9 R10 R11
    cull_now = !p_line && (area2 == 0 || (ctrl[`LPR_B_CULL] &&
               ctrl[`LPR_B_DFACE + (front ? 0 : 1)])); // R4 R12
    for (int i = 0; i < 3; i++) begin
      dxe = 36'(px[(i+2)%3]) - 36'(px[(i+1)%3]);
      dye = 36'(py[(i+2)%3]) - 36'(py[(i+1)%3]);
      if (neg) begin
        dxe = -dxe;
        dye = -dye;
      end
      // Opposite traversal of a shared edge flips this test, so one side owns it.
      incl[i] = (dye > 0) || (dye == 0 && dxe < 0); // R13
    end
    m    = p_line ? 18'(hw) + 18'sh10 : 18'sh0;
    lo_x = 18'(p_line ? ((px[0] < px[1]) ? px[0] : px[1]) :
           ((px[0] < px[1]) ? ((px[0] < px[2]) ? px[0] : px[2]) :
           ((px[1] < px[2]) ? px[1] : px[2]))) - m;
    lo_y = 18'(p_line ? ((py[0] < py[1]) ? py[0] : py[1]) :
           ((py[0] < py[1]) ? ((py[0] < py[2]) ? py[0] : py[2]) :
           ((py[1] < py[2]) ? py[1] : py[2]))) - m;
    hi_x = 18'(p_line ? ((px[0] > px[1]) ? px[0] : px[1]) :
           ((px[0] > px[1]) ? ((px[0] > px[2]) ? px[0] : px[2]) :
           ((px[1] > px[2]) ? px[1] : px[2]))) + m;
    hi_y = 18'(p_line ? ((py[0] > py[1]) ? py[0] : py[1]) :
           ((py[0] > py[1]) ? ((py[0] > py[2]) ? py[0] : py[2]) :
           ((py[1] > py[2]) ? py[1] : py[2]))) + m;
  end

  // Per-point coverage and depth; point NS is the pixel center.
  logic [NS-1:0]       cv;
  logic [NS-1:0][15:0] sz;

  for (genvar j = 0; j <= NS; j++) begin : g_pt
    localparam logic [3:0] OX = (j == NS) ? `LPR_CENTER : 4'((2 * (j % SGRID) + 1) * 8 / SGRID);
    localparam logic [3:0] OY = (j == NS) ? `LPR_CENTER : 4'((2 * (j / SGRID) + 1) * 8 / SGRID);
    logic signed [15:0] sx;
    logic signed [15:0] sy;
    logic signed [35:0] e [3];
    logic [35:0]        ec [3];
    logic signed [19:0] along;
    logic signed [19:0] perp;
    logic [31:0]        sidx;
    logic [23:0]        cnt;
    logic               cov;
    logic [15:0]        zq;

    assign sx = $signed({1'b0, cur_x, OX});
    assign sy = $signed({1'b0, cur_y, OY});

    always_comb begin
      logic signed [35:0] lx;
      logic signed [35:0] ly;
      logic               in_tri;
      logic               in_line;
      in_tri  = 1'b0;
      in_line = 1'b0;
      lx = 36'(sx) - 36'(px[0]);
      ly = 36'(sy) - 36'(py[0]);
      // Distance along and across the segment, in sixteenths of a pixel.
      along = 20'((lx * 36'(pux) + ly * 36'(puy)) >>> 14); // R8
      perp  = 20'((ly * 36'(pux) - lx * 36'(puy)) >>> 14);
      in_line = (along >= 0) && (along < $signed({4'h0, plen})) &&
                ((perp < 0 ? -perp : perp) <= $signed({9'h0, hw})); // R1 R6
      in_tri = 1'b1;
      for (int i = 0; i < 3; i++) begin
        // Vertex weight is the area facing it, so it is exactly one at that vertex.
        e[i] = lpr_edge(px[(i+1)%3], py[(i+1)%3], px[(i+2)%3], py[(i+2)%3], sx, sy); // R17
        if (neg) e[i] = -e[i];
        in_tri = in_tri && (e[i] > 0 || (e[i] == 0 && incl[i])); // R13
      end
      if (p_line) begin
        e[0] = 36'($signed({4'h0, plen})) - 36'(along); // R8
        e[1] = 36'(along);
        e[2] = 36'sh0;
      end
      for (int i = 0; i < 3; i++) ec[i] = (e[i] < 0) ? 36'h0 : e[i];
      // Each one-pixel piece of the rectangle takes the next counter value.
      cnt  = stip_base + 24'(along[19:4]); // R3 R21
      sidx = lpr_udiv({40'h0, cnt}, {31'h0, lrep}); // R20
      cov  = p_line ? (in_line && (!ctrl[`LPR_B_LSTEN] || lpat[sidx[3:0]])) : in_tri; // R3 R7
      zq   = 16'(lpr_udiv(lpr_wsum(ec[0], ec[1], ec[2], pz[0], pz[1], pz[2]),
                          40'(ec[0]) + 40'(ec[1]) + 40'(ec[2]))); // R8 R15
    end

    if (j < NS) begin : g_s
      assign cv[j] = cov;
      assign sz[j] = zq;
    end
  end

  // Center attributes.
  logic [35:0]             eq [3];
  logic [39:0]             den_l;
  logic [39:0]             den_p;
  logic [NATTR-1:0][AW-1:0] aval;

  always_comb begin
    for (int i = 0; i < 3; i++) eq[i] = 36'((64'(g_pt[NS].ec[i]) * 64'(pq[i])) >> 16); // R14
    den_l = 40'(g_pt[NS].ec[0]) + 40'(g_pt[NS].ec[1]) + 40'(g_pt[NS].ec[2]);
    den_p = 40'(eq[0]) + 40'(eq[1]) + 40'(eq[2]); // R14
  end

  for (genvar a = 0; a < NATTR; a++) begin : g_at
    always_comb begin
      case (amode[2*a +: 2])
        `LPR_AM_FLAT: aval[a] = pattr[p_prov][a]; // R16
        `LPR_AM_NOPERSP: aval[a] = AW'(lpr_udiv(lpr_wsum(g_pt[NS].ec[0], g_pt[NS].ec[1],
                           g_pt[NS].ec[2], 16'(pattr[0][a]), 16'(pattr[1][a]),
                           16'(pattr[2][a])), den_l)); // R16
        default: aval[a] = AW'(lpr_udiv(lpr_wsum(eq[0], eq[1], eq[2], 16'(pattr[0][a]),
                           16'(pattr[1][a]), 16'(pattr[2][a])), den_p)); // R14 R16
      endcase
    end
  end

  // Fragment decision and scan stepping.
  logic          multi;
  logic          pst_ok;
  logic          keep_px;
  logic          out_free;
  logic          load;
  logic          advance;
  logic          last_px;
  logic [NS-1:0] mask;

  assign multi    = msaa || (p_line && laa); // R6
  assign pst_ok   = !ctrl[`LPR_B_PSTEN] || pstip[cur_y[4:0]][cur_x[4:0]]; // R18 R19
  assign keep_px  = (multi ? |cv : g_pt[NS].cov) && (p_line || pst_ok); // R4 R13 R18 R22
  assign mask     = multi ? cv : {NS{1'b1}}; // R7
  assign out_free = !frag_valid_o || frag_ready_i;
  assign load     = (state == S_SCAN) && keep_px && out_free; // R22
  assign advance  = (state == S_SCAN) && (!keep_px || out_free); // R22
  assign last_px  = (cur_x == lpr_pix(hi_x)) && (cur_y == lpr_pix(hi_y));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cur_x <= 11'h0;
      cur_y <= 11'h0;
    end else begin
      case (state)
        S_IDLE: if (prim_valid_i) state <= S_SETUP;
        S_SETUP: begin
          state <= cull_now ? S_IDLE : S_SCAN; // R12
          cur_x <= lpr_pix(lo_x);
          cur_y <= lpr_pix(lo_y);
        end
        S_SCAN: if (advance) begin
          if (last_px) state <= S_IDLE;
          if (cur_x == lpr_pix(hi_x)) begin
            cur_x <= lpr_pix(lo_x);
            cur_y <= cur_y + 11'h1;
          end else begin
            cur_x <= cur_x + 11'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stip_base <= 24'h0; // R5
    end else if (prim_valid_i && prim_ready_o && prim_restart_i) begin
      stip_base <= 24'h0; // R21
    end else if (state == S_SCAN && advance && last_px && p_line) begin
      stip_base <= stip_base + 24'((plen + 16'h000F) >> 4); // R3 R21
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      front_r  <= 1'b0;
      culled_r <= 1'b0;
    end else if (state == S_SETUP) begin
      front_r  <= front;
      culled_r <= cull_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frag_valid_o     <= 1'b0;
      frag_x_o         <= 11'h0;
      frag_y_o         <= 11'h0;
      frag_front_o     <= 1'b0;
      frag_cov_mask_o  <= '0;
      frag_cov_count_o <= '0;
      frag_z_o         <= 16'h0;
      frag_sample_z_o  <= '0;
      frag_attr_o      <= '0;
    end else if (load) begin
      frag_valid_o     <= 1'b1; // R22
      frag_x_o         <= cur_x;
      frag_y_o         <= cur_y;
      frag_front_o     <= p_line ? 1'b1 : front;
      frag_cov_mask_o  <= mask; // R7
      frag_cov_count_o <= CW'($countones(mask)); // R1
      frag_z_o         <= g_pt[NS].zq; // R15
      frag_sample_z_o  <= sz; // R8
      frag_attr_o      <= aval;
    end else if (frag_ready_i) begin
      frag_valid_o     <= 1'b0;
    end
  end

  // Bus answer one cycle after the request.
  always_comb begin
    rdata = 32'h0;
    if (wb_adr_i[7]) rdata = pstip[wb_adr_i[6:2]];
    else if (wb_adr_i == `LPR_A_CTRL) rdata = ctrl;
    else if (wb_adr_i == `LPR_A_LINEW) rdata = {20'h0, line_w};
    else if (wb_adr_i == `LPR_A_LSTIP) rdata = {7'h0, lrep, lpat};
    else if (wb_adr_i == `LPR_A_AMODE) rdata = amode;
    else if (wb_adr_i == `LPR_A_STAT) rdata = {stip_base[15:0], 13'h0, culled_r, front_r,
                                               state != S_IDLE};
    else if (wb_adr_i == `LPR_A_WINFO) rdata = {AA_WSTEPS, AA_WMAX, `LPR_R_LINEW}; // R2
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  // Checks.
  logic [AW-1:0] flat0;
  assign flat0 = pattr[p_prov][0];

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reset_state;
    $past(rst_i) |-> line_w == `LPR_R_LINEW && lpat == `LPR_R_PAT && lrep == `LPR_R_REP &&
                     !laa && !ctrl[`LPR_B_LSTEN] && !ctrl[`LPR_B_CULL];
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("line state reset wrong"); // R5

  property p_cull;
    load && !p_line |-> !(ctrl[`LPR_B_CULL] && ctrl[`LPR_B_DFACE + (front ? 0 : 1)]);
  endproperty
  a_cull: assert property (p_cull) else $error("fragment of a discarded face"); // R12

  property p_hold;
    frag_valid_o && !frag_ready_i |=> frag_valid_o && $stable(frag_x_o) && $stable(frag_y_o);
  endproperty
  a_hold: assert property (p_hold) else $error("fragment dropped under stall"); // R22

  property p_pstip;
    load && !p_line && ctrl[`LPR_B_PSTEN] |-> pstip[cur_y[4:0]][cur_x[4:0]];
  endproperty
  a_pstip: assert property (p_pstip) else $error("stippled-out fragment sent"); // R18

  property p_zero;
    load && !p_line |-> area2 != 0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero-area polygon produced fragment"); // R11

  property p_front;
    load && !p_line |=> frag_front_o == $past(front);
  endproperty
  a_front: assert property (p_front) else $error("facing output wrong"); // R11

  property p_flat;
    load && amode[1:0] == `LPR_AM_FLAT |=> frag_attr_o[0] == $past(flat0);
  endproperty
  a_flat: assert property (p_flat) else $error("flat attribute not provoking value"); // R16

  property p_count;
    frag_valid_o |-> frag_cov_count_o == CW'($countones(frag_cov_mask_o));
  endproperty
  a_count: assert property (p_count) else $error("coverage count mismatch"); // R1

  property p_restart;
    prim_valid_i && prim_ready_o && prim_restart_i |=> stip_base == 24'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("stipple counter not cleared"); // R21

  property p_lstip;
    load && p_line && !multi && ctrl[`LPR_B_LSTEN] |-> lpat[g_pt[NS].sidx[3:0]];
  endproperty
  a_lstip: assert property (p_lstip) else $error("line stipple bit zero but sent"); // R20

  c_line: cover property (load && p_line && multi);
  c_tri: cover property (load && !p_line);
  c_cull: cover property (state == S_SETUP && cull_now && area2 != 0);
  c_stall: cover property (frag_valid_o && !frag_ready_i && state == S_SCAN && keep_px);

endmodule

// *** sim/lpr_frag_sink.sv ***
// Downstream per-fragment stage model that takes fragments and counts them.
// Assumes the rasterizer's clock; it stalls one cycle in three to hold data back.
`timescale 1ns/1ps
module lpr_frag_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Fragments
  input  wire logic        frag_valid_i,
  output logic             frag_ready_o,
  output logic      [31:0] count_o
);
  logic [1:0] phase;
  assign frag_ready_o = (phase != 2'h2);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 32'h0;
    end else if (frag_valid_i && frag_ready_o) begin
      count_o <= count_o + 32'h1;
    end
  end
endmodule

// *** sim/tb_lpr_raster.sv ***
// Self-checking bench of the rasterizer: registers, culling, winding and stipples.
// Assumes the fragment sink model beside it and the default parameters.
`timescale 1ns/1ps
`include "lpr_defs.svh"
module tb_lpr_raster;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic              ack;
  logic              pv = 1'b0;
  logic              pline = 1'b0;
  logic              pready;
  logic [2:0][15:0]  vx = '0;
  logic [2:0][15:0]  vy = '0;
  logic [15:0]       len = 16'h0000;
  logic [3:0]        sel = 4'hF;
  logic [2:0][15:0]  vz = {3{16'h1234}};
  logic [15:0]       fz;
  logic              fvalid;
  logic              fready;
  logic [31:0]       cnt;
  logic [31:0]       q;
  int                n_errors = 0;
  int                n_compared = 0;
  int                cycles = 0;
  always #4 clk = ~clk;
  lpr_raster lpr_raster_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .prim_valid_i(pv), .prim_ready_o(pready), .prim_line_i(pline),
    .prim_restart_i(pline), .prim_provoke_i(2'h0), .v_x_i(vx), .v_y_i(vy), .v_z_i(vz),
    .v_q_i({3{16'h8000}}), .v_attr_i('0), .line_ux_i(16'h4000), .line_uy_i(16'h0000),
    .line_len_i(len), .frag_valid_o(fvalid), .frag_ready_i(fready), .frag_x_o(),
    .frag_y_o(), .frag_front_o(), .frag_cov_mask_o(), .frag_cov_count_o(), .frag_z_o(fz),
    .frag_sample_z_o(), .frag_attr_o());
  lpr_frag_sink lpr_frag_sink_inst (.clk_i(clk), .rst_i(rst), .frag_valid_i(fvalid),
    .frag_ready_o(fready), .count_o(cnt));
  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Offers one primitive, waits for the scan to end and checks the fragments taken.
  task automatic draw(input logic ln, input logic [15:0] x1, y0, y2, input logic [31:0] exp);
    logic [31:0] base;
    base = cnt;
    @(posedge clk);
    pv <= 1'b1;
    pline <= ln;
    vx <= {16'h0000, x1, 16'h0000};
    vy <= {y2, y0, y0};
    len <= x1;
    do @(posedge clk); while (pready !== 1'b1);
    pv <= 1'b0;
    repeat (2) @(posedge clk);
    do @(posedge clk); while (pready !== 1'b1);
    repeat (8) @(posedge clk);
    check(cnt - base, exp);
  endtask
  task automatic t_reset();
    wb(1'b0, `LPR_A_CTRL, 32'h0);
    check(q, 32'h0000_0088);
    wb(1'b0, `LPR_A_LINEW, 32'h0);
    check(q, 32'h0000_0010);
    wb(1'b0, `LPR_A_LSTIP, 32'h0);
    check(q, 32'h0001_FFFF);
    wb(1'b0, `LPR_A_WINFO, 32'h0);
    check(q, 32'h3104_0010);
    // Byte-lane writes that push the width past each end of its range.
    sel <= 4'h2;
    wb(1'b1, `LPR_A_LINEW, 32'h0000_0300);
    wb(1'b0, `LPR_A_LINEW, 32'h0);
    check(q, 32'h0000_0040);
    sel <= 4'h1;
    wb(1'b1, `LPR_A_LINEW, 32'h0000_0005);
    sel <= 4'hF;
    wb(1'b0, `LPR_A_LINEW, 32'h0);
    check(q, 32'h0000_0010);
    wb(1'b1, `LPR_A_AMODE, 32'hFFFF_FFF2);
    wb(1'b0, `LPR_A_AMODE, 32'h0);
    check(q, 32'h0000_0002);
    wb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
  endtask
  // Right triangle of legs 4.5 pixels, anticlockwise: ten centres inside.
  task automatic t_cull();
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd10);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_00E8);
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd0);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0078);
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd10);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0060);
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd10);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0188);
    wb(1'b1, 8'h80, 32'h0000_0005);
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd8);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0088);
    draw(1'b0, 16'h0048, 16'h0000, 16'h0048, 32'd10);
  endtask
  task automatic t_lstip();
    wb(1'b1, `LPR_A_CTRL, 32'h0000_008A);
    wb(1'b1, `LPR_A_LSTIP, 32'h0001_0000);
    draw(1'b1, 16'h0040, 16'h0008, 16'h0000, 32'd0);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0088);
    draw(1'b1, 16'h0040, 16'h0012, 16'h0000, 32'd4);
    wb(1'b1, `LPR_A_CTRL, 32'h0000_0089);
    draw(1'b1, 16'h0040, 16'h0012, 16'h0000, 32'd8);
    check({16'h0, fz}, 32'h0000_1234);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cull();
    t_lstip();
    finish_test();
  end
endmodule
